// >>> inc/safe_io_defs.svh
// Offsets, field positions, reset values and timing for the safe I/O block
`ifndef SAFE_IO_DEFS_SVH
`define SAFE_IO_DEFS_SVH

`define ADDR_SRC_SEL_0 8'h00
`define ADDR_SRC_SEL_1 8'h04
`define ADDR_SRC_SEL_2 8'h08
`define ADDR_SRC_SEL_3 8'h0C
`define ADDR_PAIR_SEL_0 8'h10
`define ADDR_PAIR_SEL_1 8'h14
`define ADDR_CTRL 8'h18
`define ADDR_LEVELS 8'h1C
`define ADDR_IRQ_STATUS 8'h20
`define ADDR_IRQ_MASK 8'h24

`define CTRL_PIN_EN_LSB 0
`define CTRL_POUT_EN_LSB 2
`define LVL_IN_LSB 0
`define LVL_OUT_LSB 4
`define LVL_PIN_LSB 8
`define LVL_POUT_LSB 10
`define LVL_PFAIL_LSB 12

`define SRC_SEL_RST_0 8'hFF
`define SRC_SEL_RST_1 8'hFF
`define SRC_SEL_RST_2 8'h00
`define SRC_SEL_RST_3 8'hFF
`define PAIR_SEL_RST 8'h00
`define CTRL_RST 4'h0
`define IRQ_MASK_RST 2'h0

`define CODE_OFF 8'h00
`define CODE_FUNC_LAST 8'h40
`define CODE_READY 8'h43
`define CODE_RESTART_AX1 8'h45
`define CODE_RESTART_AX2 8'h46
`define CODE_ALWAYS_ON 8'hFF

`define MISMATCH_MS 100
`define CLK_PERIOD_NS 10

`endif

// >>> inc/safe_io_pkg.sv
// Types shared by the safe I/O block
package safe_io_pkg;

  typedef struct packed {
    logic oe;
    logic val;
  } drive_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

endpackage : safe_io_pkg

// >>> design/pair_supervisor.sv
// Disagreement timer for one pair of safe inputs
`timescale 1ns/10ps
module pair_supervisor #(
  parameter int unsigned LIMIT = 10000000,
  parameter int unsigned CNT_W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pair
  input wire logic en_i,
  input wire logic a_i,
  input wire logic b_i,
  // Fault level
  output logic fault_o
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  wire mismatch = a_i ^ b_i;
  wire at_limit = (cnt_reg == CNT_W'(LIMIT));

  // Restart from zero on agreement or when supervision is off
  assign cnt_next = (!en_i || !mismatch) ? '0 : (at_limit ? cnt_reg : cnt_reg + CNT_W'(1));
  // Fires on the mismatch cycle after LIMIT mismatching cycles
  assign fault_o = en_i & mismatch & at_limit;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : pair_supervisor

// >>> design/safe_io_top.sv
// Safe I/O source routing, pairing, supervision and Wishbone registers
`timescale 1ns/10ps
`include "safe_io_defs.svh"
module safe_io_top #(
  parameter int unsigned FUNC_W = 65,
  parameter int unsigned MISMATCH_CYCLES = `MISMATCH_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int unsigned CNT_W = 24
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Safety function states and restart requests
  input wire logic [FUNC_W-1:0] func_state_i,
  input wire logic [1:0] restart_ack_req_i,
  // Safe pins
  input wire logic [3:0] safe_in_i,
  output logic [3:0] safe_out_o,
  output logic [3:0] safe_out_oe_o,
  // Status
  output logic safe_state_o,
  output logic irq_o
);

  // Reset release
  logic rst_meta_reg;
  logic rst_ok_reg;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_ok_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_ok_reg <= rst_meta_reg;
    end
  end

  // Pin synchroniser
  logic [3:0] in_meta_reg;
  logic [3:0] in_sync_reg;
  always_ff @(posedge mclk_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      in_meta_reg <= 4'h0;
      in_sync_reg <= 4'h0;
    end else begin
      in_meta_reg <= safe_in_i;
      in_sync_reg <= in_meta_reg;
    end
  end

  // Bus request
  safe_io_pkg::wb_req_type req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [7:0] src_sel_reg [4];
  logic [7:0] pair_sel_reg [2];
  logic [3:0] ctrl_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic [13:0] levels_reg;
  logic [3:0] out_reg;
  logic [3:0] oe_reg;
  logic safe_reg;
  logic irq_reg;

  wire access = req.cyc & req.stb & ~ack_reg;
  wire wr_lo = access & req.we & req.sel[0];
  wire [1:0] pin_en = ctrl_reg[`CTRL_PIN_EN_LSB +: 2];
  wire [1:0] pout_en = ctrl_reg[`CTRL_POUT_EN_LSB +: 2];
  wire safe_now = |status_reg;

  // Source code to pin drive
  function automatic safe_io_pkg::drive_type route_src(input logic [7:0] code,
                                                       input logic [FUNC_W-1:0] func,
                                                       input logic [1:0] rak);
    safe_io_pkg::drive_type d;
    d.oe = 1'b1;
    d.val = 1'b0;
    if (code == `CODE_OFF) begin
      d.oe = 1'b0;
    end else if (code == `CODE_ALWAYS_ON || code == `CODE_READY) begin
      d.val = 1'b1;
    end else if (code == `CODE_RESTART_AX1) begin
      d.val = rak[0];
    end else if (code == `CODE_RESTART_AX2) begin
      d.val = rak[1];
    end else if (code <= `CODE_FUNC_LAST && 32'(code) < FUNC_W) begin
      d.val = func[code[6:0]];
    end
    return d;
  endfunction : route_src

  // Per-output routing
  safe_io_pkg::drive_type drv [4];
  wire [3:0] out_next;
  wire [3:0] oe_next;
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_out
      // Unpaired output follows its own selector, paired one the pair selector
      wire [7:0] code = pout_en[k/2] ? pair_sel_reg[k/2] : src_sel_reg[k];
      assign drv[k] = route_src(code, func_state_i, restart_ack_req_i);
      // Safe state still drives, but low
      assign out_next[k] = drv[k].val & ~safe_now;
      assign oe_next[k] = drv[k].oe;
    end
  endgenerate

  // Single process so each pin register has one driver
  always_ff @(posedge mclk_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  // Pair supervision
  logic [1:0] fault;
  logic [1:0] mismatch;
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      assign mismatch[p] = in_sync_reg[2*p] ^ in_sync_reg[2*p+1];
      pair_supervisor #(
        .LIMIT(MISMATCH_CYCLES),
        .CNT_W(CNT_W)
      ) u_sup (
        .clk_i(mclk_i),
        .rst_n_i(rst_ok_reg),
        .en_i(pin_en[p]),
        .a_i(in_sync_reg[2*p]),
        .b_i(in_sync_reg[2*p+1]),
        .fault_o(fault[p])
      );
    end
  endgenerate

  // Set wins over write-one-to-clear
  wire w1c = wr_lo & (req.adr == `ADDR_IRQ_STATUS);
  assign status_next = (status_reg & ~(w1c ? req.dat[1:0] : 2'h0)) | fault;

  // Level snapshot; unequal pairs read 0, and unequal input pairs also set the failure bit
  wire [1:0] pin_lvl = {&in_sync_reg[3:2], &in_sync_reg[1:0]};
  wire [1:0] pout_lvl = {&out_reg[3:2], &out_reg[1:0]};
  wire [13:0] levels_next = {mismatch, pout_lvl, pin_lvl, out_reg, in_sync_reg};

  // Read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (req.adr)
      `ADDR_SRC_SEL_0: rd_data = {24'h00_0000, src_sel_reg[0]};
      `ADDR_SRC_SEL_1: rd_data = {24'h00_0000, src_sel_reg[1]};
      `ADDR_SRC_SEL_2: rd_data = {24'h00_0000, src_sel_reg[2]};
      `ADDR_SRC_SEL_3: rd_data = {24'h00_0000, src_sel_reg[3]};
      `ADDR_PAIR_SEL_0: rd_data = {24'h00_0000, pair_sel_reg[0]};
      `ADDR_PAIR_SEL_1: rd_data = {24'h00_0000, pair_sel_reg[1]};
      `ADDR_CTRL: rd_data = {28'h000_0000, ctrl_reg};
      `ADDR_LEVELS: rd_data = {18'h0_0000, levels_reg};
      `ADDR_IRQ_STATUS: rd_data = {30'h0000_0000, status_reg};
      `ADDR_IRQ_MASK: rd_data = {30'h0000_0000, mask_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= access;
      rdat_reg <= access ? rd_data : 32'h0000_0000;
    end
  end

  // Configuration writes; full 8-bit code range is accepted
  always_ff @(posedge mclk_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      src_sel_reg[0] <= `SRC_SEL_RST_0;
      src_sel_reg[1] <= `SRC_SEL_RST_1;
      src_sel_reg[2] <= `SRC_SEL_RST_2;
      src_sel_reg[3] <= `SRC_SEL_RST_3;
      pair_sel_reg[0] <= `PAIR_SEL_RST;
      pair_sel_reg[1] <= `PAIR_SEL_RST;
      ctrl_reg <= `CTRL_RST;
      mask_reg <= `IRQ_MASK_RST;
    end else if (wr_lo) begin
      case (req.adr)
        `ADDR_SRC_SEL_0: src_sel_reg[0] <= req.dat[7:0];
        `ADDR_SRC_SEL_1: src_sel_reg[1] <= req.dat[7:0];
        `ADDR_SRC_SEL_2: src_sel_reg[2] <= req.dat[7:0];
        `ADDR_SRC_SEL_3: src_sel_reg[3] <= req.dat[7:0];
        `ADDR_PAIR_SEL_0: pair_sel_reg[0] <= req.dat[7:0];
        `ADDR_PAIR_SEL_1: pair_sel_reg[1] <= req.dat[7:0];
        `ADDR_CTRL: ctrl_reg <= req.dat[3:0];
        `ADDR_IRQ_MASK: mask_reg <= req.dat[1:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      status_reg <= 2'h0;
      levels_reg <= 14'h0000;
      safe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      levels_reg <= levels_next;
      safe_reg <= |status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign safe_out_o = out_reg;
  assign safe_out_oe_o = oe_reg;
  assign safe_state_o = safe_reg;
  assign irq_o = irq_reg;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_ok_reg);

  sequence s_fault0;
    fault[0] ##1 status_reg[0];
  endsequence

  sequence s_agree0;
    !mismatch[0] ##1 !mismatch[0];
  endsequence

  property p_off_not_driven;
    !pout_en[0] && src_sel_reg[0] == `CODE_OFF |=> !safe_out_oe_o[0];
  endproperty
  a_off_not_driven: assert property (p_off_not_driven) else $error("Off code still drives output");

  property p_always_on;
    !pout_en[0] && src_sel_reg[0] == `CODE_ALWAYS_ON && !safe_now |=> safe_out_o[0] && safe_out_oe_o[0];
  endproperty
  a_always_on: assert property (p_always_on) else $error("Always-on code not high");

  property p_restart_route;
    !pout_en[1] && src_sel_reg[3] == `CODE_RESTART_AX2 && !safe_now |=>
      safe_out_o[3] == $past(restart_ack_req_i[1]);
  endproperty
  a_restart_route: assert property (p_restart_route) else $error("Restart request not routed");

  property p_ready_single;
    !pout_en[1] && src_sel_reg[2] == `CODE_READY && !safe_now |=> safe_out_o[2];
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("Ready code not high");

  property p_reset_defaults;
    $rose(rst_ok_reg) |-> src_sel_reg[0] == 8'hFF && src_sel_reg[1] == 8'hFF && src_sel_reg[2] == 8'h00
      && src_sel_reg[3] == 8'hFF;
  endproperty
  a_reset_defaults: assert property (@(posedge mclk_i) p_reset_defaults) else $error("Bad selector default");

  property p_pair_in_level;
    s_agree0 |=> levels_reg[`LVL_PIN_LSB] == $past(in_sync_reg[0]) && !levels_reg[`LVL_PFAIL_LSB];
  endproperty
  a_pair_in_level: assert property (p_pair_in_level) else $error("Paired input level wrong");

  property p_fault_safe;
    s_fault0 |-> safe_state_o ##1 safe_out_o == 4'h0;
  endproperty
  a_fault_safe: assert property (p_fault_safe) else $error("Fault did not force safe state");

  property p_agree_no_fault;
    !mismatch[0] || !pin_en[0] |-> !fault[0];
  endproperty
  a_agree_no_fault: assert property (p_agree_no_fault) else $error("Fault without disagreement");

  property p_in_levels;
    1'b1 |=> levels_reg[3:0] == $past(in_sync_reg);
  endproperty
  a_in_levels: assert property (p_in_levels) else $error("Input levels stale");

  property p_pair_out_same;
    pout_en[0] |=> safe_out_o[0] == safe_out_o[1] && safe_out_oe_o[0] == safe_out_oe_o[1];
  endproperty
  a_pair_out_same: assert property (p_pair_out_same) else $error("Paired outputs differ");

  property p_pair_sel_off;
    pout_en[1] && pair_sel_reg[1] == `CODE_OFF |=> !safe_out_oe_o[2] && !safe_out_oe_o[3];
  endproperty
  a_pair_sel_off: assert property (p_pair_sel_off) else $error("Pair selector ignored");

  property p_set_wins;
    fault[1] |=> status_reg[1] && irq_o == |(status_reg & $past(mask_reg));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Fault lost against clear");

  property p_out_levels;
    1'b1 |=> levels_reg[7:4] == $past(safe_out_o)
      && levels_reg[`LVL_POUT_LSB] == $past(safe_out_o[0] & safe_out_o[1]);
  endproperty
  a_out_levels: assert property (p_out_levels) else $error("Output levels stale");

endmodule : safe_io_top

// >>> tb/safe_field_model.sv
// Field sensors with channel skew and pulled-down actuator lines
`timescale 1ns/10ps
module safe_field_model (
  // Clock
  input wire logic clk_i,
  // Sensor command and skew of second channels
  input wire logic [3:0] sense_i,
  input wire logic [5:0] lag_i,
  // Actuator side
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  output logic [3:0] pin_o,
  output logic [3:0] load_o
);
  logic [63:0] hist_a = '0;
  logic [63:0] hist_b = '0;
  always @(posedge clk_i) begin
    hist_a <= {hist_a[62:0], sense_i[1]};
    hist_b <= {hist_b[62:0], sense_i[3]};
  end
  // Second member trails the first, as slow contacts do
  assign pin_o[0] = sense_i[0];
  assign pin_o[1] = (lag_i == 6'h00) ? sense_i[1] : hist_a[lag_i - 6'h01];
  assign pin_o[2] = sense_i[2];
  assign pin_o[3] = (lag_i == 6'h00) ? sense_i[3] : hist_b[lag_i - 6'h01];
  // Pull-down on actuator lines when released
  assign load_o = out_i & oe_i;
endmodule : safe_field_model

// >>> tb/safe_io_mapping_supervision_bench.sv
// Self-checking bench for the safe I/O block
`timescale 1ns/10ps
`include "safe_io_defs.svh"
module safe_io_mapping_supervision_bench;
  localparam int LIM = 20;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat, q;
  logic ack, sstate, irq;
  logic [64:0] func = '0;
  logic [1:0] rak = '0;
  logic [3:0] sense = '0;
  logic [3:0] pin, sout, soe, load;
  logic [5:0] lag = '0;
  logic [15:0] lfsr = 16'h001E;
  logic [7:0] codes [6] = '{8'h00, 8'h43, 8'hFF, 8'h45, 8'h46, 8'h41};
  logic [7:0] rv [8] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  int num_errors = 0;
  int compares = 0;
  safe_io_pkg::drive_type d;

  always #5 mclk_i = ~mclk_i;

  safe_io_top #(.MISMATCH_CYCLES(LIM)) u_safe_io_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .func_state_i(func), .restart_ack_req_i(rak), .safe_in_i(pin),
    .safe_out_o(sout), .safe_out_oe_o(soe), .safe_state_o(sstate), .irq_o(irq));
  safe_field_model u_safe_field_model (.clk_i(mclk_i), .sense_i(sense), .lag_i(lag), .out_i(sout),
    .oe_i(soe), .pin_o(pin), .load_o(load));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  function automatic safe_io_pkg::drive_type exp_drv(input logic [7:0] c);
    safe_io_pkg::drive_type r;
    r.oe = (c != `CODE_OFF);
    case (c)
      `CODE_OFF: r.val = 1'b0;
      `CODE_READY, `CODE_ALWAYS_ON: r.val = 1'b1;
      `CODE_RESTART_AX1: r.val = rak[0];
      `CODE_RESTART_AX2: r.val = rak[1];
      default: r.val = (c <= `CODE_FUNC_LAST) ? func[c] : 1'b0;
    endcase
    return r;
  endfunction : exp_drv

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic results();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Classic single cycle; waits for ack, never a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= dt;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      check("bus timeout", 32'h0000_0000, 32'h0000_0001);
      results();
    end
  endtask : xfer

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  initial begin
    repeat (20000) @(posedge mclk_i);
    check("watchdog", 32'h0000_0000, 32'h0000_0001);
    results();
  end

  initial begin
    logic [7:0] c;
    logic [79:0] big;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    tick(3);
    check("reset drive", 32'h0000_00BB, {24'h00_0000, soe, sout});
    check("reset load", 32'h0000_000B, {28'h000_0000, load});
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, (i < 7) ? 8'(4 * i) : `ADDR_IRQ_MASK, 32'h0000_0000);
      check("reset reg", {24'h00_0000, rv[i]}, q);
    end
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 8; k++) begin
        big = {rnd(), rnd(), rnd(), rnd(), rnd()};
        c = (k < 6) ? codes[k] : (k == 6) ? {2'b00, big[5:0]} + 8'h01 : big[15:8];
        @(posedge mclk_i);
        func <= big[64:0];
        rak <= big[79:78];
        xfer(1'b1, 8'(4 * i), {24'h00_0000, c});
        tick(1);
        d = exp_drv(c);
        check("single out", {30'h0, d.oe, d.val}, {30'h0, soe[i], sout[i]});
        check("load", {31'h0, d.oe & d.val}, {31'h0, load[i]});
        xfer(1'b0, `ADDR_LEVELS, 32'h0000_0000);
        check("out level", {31'h0, d.val}, {31'h0, q[4 + i]});
      end
    end
    $display("single sources done");
    xfer(1'b1, `ADDR_SRC_SEL_0, 32'h0000_0000);
    xfer(1'b1, `ADDR_SRC_SEL_1, 32'h0000_00FF);
    xfer(1'b1, `ADDR_CTRL, 32'h0000_000C);
    for (int k = 0; k < 6; k++) begin
      xfer(1'b1, `ADDR_PAIR_SEL_0, {24'h00_0000, codes[k]});
      tick(1);
      d = exp_drv(codes[k]);
      check("pair out", {28'h0, d.oe, d.oe, d.val, d.val}, {28'h0, soe[1:0], sout[1:0]});
      check("pair off", 32'h0000_0000, {28'h0, soe[3:2], sout[3:2]});
      xfer(1'b0, `ADDR_LEVELS, 32'h0000_0000);
      check("pair out level", {31'h0, d.val}, {31'h0, q[10]});
    end
    xfer(1'b1, `ADDR_CTRL, 32'h0000_0000);
    $display("paired outputs done");
    for (int k = 0; k < 12; k++) begin
      @(posedge mclk_i);
      sense <= 4'(rnd());
      tick(4);
      xfer(1'b0, `ADDR_LEVELS, 32'h0000_0000);
      check("in level", {24'h0, sense[3] ^ sense[2], sense[1] ^ sense[0], sense[3] & sense[2],
        sense[1] & sense[0], sense}, {24'h0, q[13:12], q[9:8], q[3:0]});
    end
    $display("input levels done");
    // Let the skewed channels settle before supervision is armed
    @(posedge mclk_i);
    sense <= 4'h0;
    lag <= 6'd15;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'(4 * i), 32'h0000_00FF);
    end
    tick(8);
    xfer(1'b1, `ADDR_CTRL, 32'h0000_0003);
    tick(4);
    // Two short skews with one agreeing cycle between must not add up
    @(posedge mclk_i);
    sense <= 4'hF;
    repeat (16) @(posedge mclk_i);
    sense <= 4'h0;
    tick(24);
    xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0000_0000);
    check("short skew", 32'h0000_0000, q);
    @(posedge mclk_i);
    lag <= 6'd30;
    sense <= 4'hF;
    tick(40);
    xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0000_0000);
    check("long skew", 32'h0000_0003, q);
    check("safe state", {31'h0, 1'b1}, {31'h0, sstate});
    check("forced out", 32'h0000_00F0, {24'h0, soe, sout});
    check("masked irq", 32'h0000_0000, {31'h0, irq});
    // A lasting disagreement holds the failure bits against a clear
    @(posedge mclk_i);
    lag <= 6'd0;
    sense <= 4'h5;
    tick(30);
    xfer(1'b1, `ADDR_IRQ_STATUS, 32'h0000_0003);
    xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0000_0000);
    check("set wins", 32'h0000_0003, q);
    @(posedge mclk_i);
    sense <= 4'h0;
    tick(4);
    xfer(1'b1, `ADDR_IRQ_MASK, 32'h0000_0001);
    tick(2);
    check("irq", 32'h0000_0001, {31'h0, irq});
    xfer(1'b1, `ADDR_IRQ_STATUS, 32'h0000_0003);
    tick(2);
    check("cleared", 32'h0000_0000, {30'h0, irq, sstate});
    tick(1);
    check("released out", 32'h0000_00FF, {24'h0, soe, sout});
    @(posedge mclk_i);
    lag <= 6'd0;
    $display("supervision done");
    results();
  end
endmodule : safe_io_mapping_supervision_bench
